// >>> logic/pmic_i2c_host.sv
`timescale 1ns/1ps
module pmic_i2c_host (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  i2c_link_if.master                link,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire logic                 cmd_read,
  input  wire logic                 cmd_hs,
  input  wire logic                 cmd_chain,
  input  wire pmic_i2c_pkg::byte_t  cmd_index,
  input  wire pmic_i2c_pkg::byte_t  cmd_wdata,
  output logic                      rsp_valid,
  output pmic_i2c_pkg::byte_t       rsp_rdata,
  output logic                      rsp_nack,
  output logic                      rsp_lost,
  output logic                      hs_active
);
  import pmic_i2c_pkg::*;

  typedef enum logic [4:0] {
    M_IDLE  = 5'b00001,
    M_START = 5'b00010,
    M_BYTE  = 5'b00100,
    M_STOP  = 5'b01000,
    M_PARK  = 5'b10000
  } host_state_t;

  host_state_t state_reg;
  logic        scl_m1, scl_s, sda_m1, sda_s;
  logic [7:0]  cnt_reg;
  logic [1:0]  q_reg;
  logic [3:0]  bit_reg;
  logic [2:0]  step_reg;
  byte_t       sh_reg, index_reg, wdata_reg, rdata_reg;
  logic        read_reg, chain_reg, hs_reg, nak_reg, lost_reg;
  logic        scl_oe_reg, sda_oe_reg, pu_reg, ready_reg, rsp_reg;

  // =====================================================
  // Line synchronisers and quarter-bit divider
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scl_m1 <= 1'b1;
      scl_s  <= 1'b1;
      sda_m1 <= 1'b1;
      sda_s  <= 1'b1;
    end else begin
      scl_m1 <= link.scl;
      scl_s  <= scl_m1;
      sda_m1 <= link.sda;
      sda_s  <= sda_m1;
    end
  end

  wire       busy     = (state_reg != M_IDLE) && (state_reg != M_PARK);
  wire       tick     = busy && (cnt_reg == 8'h00);
  // A slave holding the clock low stalls the bit at quarter one
  wire       adv      = tick && !((q_reg == 2'h1) && !scl_s);
  wire       recv     = (step_reg == 3'h5);
  wire       accept   = cmd_valid && ready_reg;
  wire       lose     = (step_reg == 3'h0) && !bit_reg[3] && !sda_oe_reg && !sda_s;
  wire [7:0] quarter  = hs_reg ? HS_QUARTER_CYC : FS_QUARTER_CYC;
  wire [7:0] start_b  = (step_reg == 3'h0) ? {MCODE_PREFIX, MASTER_CODE_ID} :
                        {SLAVE_ADDR, step_reg == 3'h4};

  always_ff @(posedge clk_sys) begin
    if (srst || !busy || tick) begin
      cnt_reg <= srst ? FS_QUARTER_CYC : quarter;
    end else begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // Pull-up only once nobody holds the clock low
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pu_reg <= 1'b0;
    end else begin
      pu_reg <= hs_reg && !scl_oe_reg && scl_s;
    end
  end

  // =====================================================
  // Transfer sequencer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg  <= M_IDLE;
      q_reg      <= 2'h0;
      bit_reg    <= 4'h0;
      step_reg   <= 3'h1;
      sh_reg     <= 8'h00;
      index_reg  <= 8'h00;
      wdata_reg  <= 8'h00;
      rdata_reg  <= 8'h00;
      read_reg   <= 1'b0;
      chain_reg  <= 1'b0;
      hs_reg     <= 1'b0;
      nak_reg    <= 1'b0;
      lost_reg   <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ready_reg  <= 1'b1;
      rsp_reg    <= 1'b0;
    end else begin
      rsp_reg <= 1'b0;
      if (adv) begin
        q_reg <= q_reg + 2'h1;
      end
      unique case (state_reg)
        M_IDLE, M_PARK: begin
          if (accept) begin
            state_reg  <= M_START;
            q_reg      <= 2'h0;
            ready_reg  <= 1'b0;
            read_reg   <= cmd_read;
            chain_reg  <= cmd_chain;
            index_reg  <= cmd_index;
            wdata_reg  <= cmd_wdata;
            nak_reg    <= 1'b0;
            lost_reg   <= 1'b0;
            step_reg   <= (cmd_hs && !hs_reg) ? 3'h0 : 3'h1;
            sda_oe_reg <= 1'b0;
          end
        end
        M_START: begin
          if (adv) begin
            unique case (q_reg)
              2'h0: scl_oe_reg <= 1'b0;
              2'h1: sda_oe_reg <= 1'b1;
              2'h2: scl_oe_reg <= 1'b1;
              2'h3: begin
                state_reg  <= M_BYTE;
                bit_reg    <= 4'h0;
                sh_reg     <= start_b;
                sda_oe_reg <= ~start_b[7];
              end
            endcase
          end
        end
        M_BYTE: begin
          if (adv) begin
            unique case (q_reg)
              2'h0: scl_oe_reg <= 1'b0;
              2'h1: begin
                if (!bit_reg[3] && recv) begin
                  sh_reg <= {sh_reg[6:0], sda_s};
                end
                // Our own NACK after a read byte is not a slave refusal
                if (bit_reg[3] && !recv) begin
                  nak_reg <= sda_s;
                end
                if (lose) begin
                  state_reg  <= M_IDLE;
                  sda_oe_reg <= 1'b0;
                  lost_reg   <= 1'b1;
                  rsp_reg    <= 1'b1;
                  ready_reg  <= 1'b1;
                end
              end
              2'h2: scl_oe_reg <= 1'b1;
              2'h3: begin
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg < 4'h7) begin
                  sda_oe_reg <= recv ? 1'b0 : ~sh_reg[6];
                  if (!recv) begin
                    sh_reg <= {sh_reg[6:0], 1'b0};
                  end
                end else if (bit_reg == 4'h7) begin
                  // Ack slot released; a read's last byte is NACKed
                  sda_oe_reg <= 1'b0;
                end else if (step_reg == 3'h0) begin
                  hs_reg     <= 1'b1;
                  step_reg   <= 3'h1;
                  state_reg  <= M_START;
                end else if (nak_reg && !recv) begin
                  state_reg  <= M_STOP;
                  sda_oe_reg <= 1'b1;
                end else if (step_reg == 3'h1 || (step_reg == 3'h2 && !read_reg)) begin
                  step_reg   <= step_reg + 3'h1;
                  bit_reg    <= 4'h0;
                  sh_reg     <= (step_reg == 3'h1) ? index_reg : wdata_reg;
                  sda_oe_reg <= (step_reg == 3'h1) ? ~index_reg[7] : ~wdata_reg[7];
                end else if (step_reg == 3'h2 || step_reg == 3'h4) begin
                  // A read skips the data step and readdresses after Sr
                  step_reg   <= (step_reg == 3'h2) ? 3'h4 : 3'h5;
                  bit_reg    <= 4'h0;
                  state_reg  <= (step_reg == 3'h2) ? M_START : M_BYTE;
                  sda_oe_reg <= 1'b0;
                end else begin
                  rdata_reg <= sh_reg;
                  if (chain_reg && hs_reg) begin
                    // Clock parked low until the next chained request
                    state_reg  <= M_PARK;
                    rsp_reg    <= 1'b1;
                    ready_reg  <= 1'b1;
                  end else begin
                    state_reg  <= M_STOP;
                    sda_oe_reg <= 1'b1;
                  end
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (adv) begin
            unique case (q_reg)
              2'h0: scl_oe_reg <= 1'b0;
              2'h1: begin
                sda_oe_reg <= 1'b0;
                // Leave Hs with the STOP edge; the registered pull-up drops one cycle after it
                hs_reg     <= 1'b0;
              end
              2'h2: ;
              2'h3: begin
                state_reg <= M_IDLE;
                rsp_reg   <= 1'b1;
                ready_reg <= 1'b1;
              end
            endcase
          end
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end

  assign link.scl_m_o      = 1'b0;
  assign link.sda_m_o      = 1'b0;
  assign link.scl_m_oe     = scl_oe_reg;
  assign link.sda_m_oe     = sda_oe_reg;
  assign link.hs_pullup_en = pu_reg;
  assign cmd_ready         = ready_reg;
  assign rsp_valid         = rsp_reg;
  assign rsp_rdata         = rdata_reg;
  assign rsp_nack          = nak_reg;
  assign rsp_lost          = lost_reg;
  assign hs_active         = hs_reg;
endmodule

// >>> inc/pmic_i2c_pkg.sv
// Functional notes
// - Answer only slave address 0x1b.
// - Work at 100 and 400 kbps.
// - Accept any byte count of one or more.
// - Hs entry: START, master code, then NACK.
// - Never acknowledge a master code.
// - Master code is never an address.
// - Masters arbitrate only during master code.
// - Own master code; avoid 0000 1000.
// - Pull-up on only after clock seen high.
// - Hs: Sr, address, slave acknowledges.
// - Pull-up off after Sr and ack; stretch allowed.
// - Hs kept over Sr, left at STOP.
// - Master may chain Hs transfers with Sr.
// - Core voltage code 0.7V-1.3V, 10mV steps.
// - Control rails, PWM mode, wake, sleep.
package pmic_i2c_pkg;
  typedef logic [7:0] byte_t;

  // =====================================================
  // Addressing
  localparam logic [6:0] SLAVE_ADDR     = 7'h1b;
  localparam logic [4:0] MCODE_PREFIX   = 5'h01;
  localparam logic [2:0] MASTER_CODE_ID = 3'h3;

  // =====================================================
  // Register file
  localparam int         REG_COUNT      = 8;
  localparam byte_t      REG_LIMIT      = 8'h08;
  localparam byte_t      REG_VCORE      = 8'h00;
  localparam byte_t      REG_RAIL       = 8'h01;
  localparam byte_t      REG_PWM        = 8'h02;
  localparam byte_t      REG_SLEEP      = 8'h03;
  localparam byte_t      REG_WAKE       = 8'h04;
  // Code 0 is 0.7V, each step 10mV, code 60 is 1.3V
  localparam byte_t      VCORE_MAX_CODE = 8'h3c;
  localparam logic [63:0] REG_RST_VEC   = 64'h0000_0000_0300_0f1e;

  // =====================================================
  // Timing of the clock-making end
  localparam int         CLK_MHZ        = 200;
  localparam int         FS_QUARTER_NS  = 625;
  localparam int         HS_QUARTER_NS  = 74;
  localparam logic [7:0] FS_QUARTER_CYC = 8'((FS_QUARTER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] HS_QUARTER_CYC = 8'((HS_QUARTER_NS * CLK_MHZ + 999) / 1000);
endpackage

// >>> inc/i2c_link_if.sv
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic scl_s_o;
  logic scl_s_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic hs_pullup_en;
  logic scl;
  logic sda;

  // =====================================================
  // Wired-AND of the open-drain drivers
  assign scl = ~((scl_m_oe & ~scl_m_o) | (scl_s_oe & ~scl_s_o));
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, hs_pullup_en,
                  input scl, sda);
  modport slave  (output scl_s_o, scl_s_oe, sda_s_o, sda_s_oe,
                  input scl, sda, hs_pullup_en);
endinterface

// >>> logic/pmic_i2c_dev.sv
`timescale 1ns/1ps
module pmic_i2c_dev (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  i2c_link_if.slave                 link,
  input  wire logic                 hold_req,
  output pmic_i2c_pkg::byte_t       vcore_code,
  output pmic_i2c_pkg::byte_t       rail_en,
  output pmic_i2c_pkg::byte_t       pwm_sel,
  output pmic_i2c_pkg::byte_t       sleep_ctrl,
  output pmic_i2c_pkg::byte_t       wake_seq,
  output logic                      hs_active
);
  import pmic_i2c_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_RX   = 7'b0000010,
    S_ACK  = 7'b0000100,
    S_NACK = 7'b0001000,
    S_TX   = 7'b0010000,
    S_RACK = 7'b0100000,
    S_WAIT = 7'b1000000
  } dev_state_t;

  dev_state_t state_reg, state_next;
  logic       scl_m1, scl_m2, scl_q, sda_m1, sda_m2, sda_q;
  byte_t      shift_reg, idx_reg;
  logic [3:0] bit_reg;
  logic       first_reg, idx_seen_reg, rw_reg, hs_reg;
  logic       sda_oe_reg, sda_oe_next, scl_oe_reg, scl_oe_next;
  byte_t      regs_reg [REG_COUNT];

  // =====================================================
  // Line synchronisers; edges are found after the second stage only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scl_m1 <= 1'b1;
      scl_m2 <= 1'b1;
      scl_q  <= 1'b1;
      sda_m1 <= 1'b1;
      sda_m2 <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      scl_m1 <= link.scl;
      scl_m2 <= scl_m1;
      scl_q  <= scl_m2;
      sda_m1 <= link.sda;
      sda_m2 <= sda_m1;
      sda_q  <= sda_m2;
    end
  end

  wire scl_rise  = scl_m2 && !scl_q;
  wire scl_fall  = !scl_m2 && scl_q;
  wire start_det = scl_m2 && scl_q && sda_q && !sda_m2;
  wire stop_det  = scl_m2 && scl_q && !sda_q && sda_m2;
  wire byte_done = (bit_reg == 4'h8);
  wire is_mcode  = (shift_reg[7:3] == MCODE_PREFIX);
  wire addr_hit  = (shift_reg[7:1] == SLAVE_ADDR);
  wire idx_ok    = (idx_reg < REG_LIMIT);
  wire rx_end    = (state_reg == S_RX) && scl_fall && byte_done;
  wire wr_en     = rx_end && !first_reg && idx_seen_reg && idx_ok;
  wire rack_ok   = (state_reg == S_RACK) && scl_rise && !sda_m2;
  // Out-of-range voltage codes saturate at the top of the range
  wire [7:0] wr_val  = ((idx_reg == REG_VCORE) && (shift_reg > VCORE_MAX_CODE)) ?
                       VCORE_MAX_CODE : shift_reg;
  wire [7:0] rd_byte = idx_ok ? regs_reg[idx_reg[2:0]] : 8'h00;
  // Stretch points: after Sr and after each acknowledge slot that carries an ACK
  wire stretch_pt = hs_reg && hold_req && scl_fall &&
                    ((state_reg == S_ACK) || (state_reg == S_RACK) ||
                     ((state_reg == S_RX) && first_reg && (bit_reg == 4'h0)));

  // =====================================================
  // Byte-level state machine
  always_comb begin
    state_next = state_reg;
    if (stop_det) begin
      state_next = S_IDLE;
    end else if (start_det) begin
      state_next = S_RX;
    end else begin
      unique case (state_reg)
        S_IDLE, S_WAIT: ;
        S_RX: begin
          if (rx_end) begin
            if (!first_reg) begin
              state_next = S_ACK;
            end else if (is_mcode) begin
              state_next = S_NACK;
            end else if (addr_hit) begin
              state_next = S_ACK;
            end else begin
              state_next = S_WAIT;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            state_next = rw_reg ? S_TX : S_RX;
          end
        end
        S_NACK: begin
          if (scl_fall) begin
            state_next = S_WAIT;
          end
        end
        S_TX: begin
          if (scl_fall && (bit_reg == 4'h7)) begin
            state_next = S_RACK;
          end
        end
        S_RACK: begin
          if (scl_rise && sda_m2) begin
            state_next = S_WAIT;
          end else if (scl_fall) begin
            state_next = S_TX;
          end
        end
      endcase
    end
  end

  always_comb begin
    sda_oe_next = (state_reg == S_ACK) || ((state_reg == S_TX) && !shift_reg[7]);
    scl_oe_next = scl_oe_reg;
    if (stop_det || !hold_req) begin
      scl_oe_next = 1'b0;
    end else if (stretch_pt) begin
      scl_oe_next = 1'b1;
    end
  end

  // =====================================================
  // Shifter, index and mode tracking
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg    <= S_IDLE;
      shift_reg    <= 8'h00;
      idx_reg      <= 8'h00;
      bit_reg      <= 4'h0;
      first_reg    <= 1'b1;
      idx_seen_reg <= 1'b0;
      rw_reg       <= 1'b0;
      hs_reg       <= 1'b0;
      sda_oe_reg   <= 1'b0;
      scl_oe_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      sda_oe_reg <= sda_oe_next && !stop_det;
      scl_oe_reg <= scl_oe_next;
      if (stop_det) begin
        hs_reg  <= 1'b0;
        bit_reg <= 4'h0;
      end else if (start_det) begin
        bit_reg      <= 4'h0;
        first_reg    <= 1'b1;
        idx_seen_reg <= 1'b0;
        rw_reg       <= 1'b0;
      end else if ((state_reg == S_RX) && scl_rise) begin
        shift_reg <= {shift_reg[6:0], sda_m2};
        bit_reg   <= bit_reg + 4'h1;
      end else if (rx_end) begin
        bit_reg   <= 4'h0;
        first_reg <= 1'b0;
        if (first_reg) begin
          rw_reg <= shift_reg[0];
        end else if (!idx_seen_reg) begin
          idx_reg      <= shift_reg;
          idx_seen_reg <= 1'b1;
        end else begin
          idx_reg <= idx_reg + 8'h01;
        end
      end else if ((state_reg == S_NACK) && scl_fall) begin
        hs_reg <= 1'b1;
      end else if (((state_reg == S_ACK) || (state_reg == S_RACK)) && scl_fall && rw_reg) begin
        shift_reg <= rd_byte;
        bit_reg   <= 4'h0;
      end else if ((state_reg == S_TX) && scl_fall) begin
        shift_reg <= {shift_reg[6:0], 1'b0};
        bit_reg   <= bit_reg + 4'h1;
      end else if (rack_ok) begin
        idx_reg <= idx_reg + 8'h01;
      end
    end
  end

  // =====================================================
  // Control registers seen by the power stages
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        regs_reg[g] <= REG_RST_VEC[8*g +: 8];
      end else if (wr_en && (idx_reg[2:0] == 3'(g))) begin
        regs_reg[g] <= wr_val;
      end
    end
  end

  assign link.scl_s_o  = 1'b0;
  assign link.sda_s_o  = 1'b0;
  assign link.scl_s_oe = scl_oe_reg;
  assign link.sda_s_oe = sda_oe_reg;
  assign vcore_code    = regs_reg[REG_VCORE[2:0]];
  assign rail_en       = regs_reg[REG_RAIL[2:0]];
  assign pwm_sel       = regs_reg[REG_PWM[2:0]];
  assign sleep_ctrl    = regs_reg[REG_SLEEP[2:0]];
  assign wake_seq      = regs_reg[REG_WAKE[2:0]];
  assign hs_active     = hs_reg;
endmodule

// >>> testbench/pmic_i2c_hs_slave_props.sv
`timescale 1ns/1ps
module pmic_i2c_hs_slave_props (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic scl_m_oe,
  input wire logic scl_s_oe,
  input wire logic sda_s_oe,
  input wire logic hs_pullup_en,
  input wire logic scl,
  input wire logic sda
);
  import pmic_i2c_pkg::*;

  // =====================================================
  // Bus event tracking on the resolved lines
  logic       scl_reg;
  logic       sda_reg;
  logic       first_reg;
  logic       hs_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  wire        scl_rise = scl & ~scl_reg;
  wire        start_ev = scl & scl_reg & sda_reg & ~sda;
  wire        stop_ev  = scl & scl_reg & ~sda_reg & sda;
  wire        ack_slot = scl_rise & (cnt_reg == 4'h8);
  wire        is_mcode = first_reg & (sh_reg[7:3] == MCODE_PREFIX);
  wire        is_addr  = first_reg & (sh_reg[7:1] == SLAVE_ADDR);

  always_ff @(posedge clk_sys) begin
    scl_reg <= scl;
    sda_reg <= sda;
    sh_reg  <= scl_rise ? {sh_reg[6:0], sda} : sh_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (srst || start_ev) begin
      cnt_reg <= 4'h0;
    end else if (scl_rise) begin
      cnt_reg <= (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
    end
  end

  // Hs flag clears at STOP at once; the design lags it by its edge detector
  always_ff @(posedge clk_sys) begin
    first_reg <= !srst && (start_ev || (first_reg && !ack_slot));
    hs_reg    <= !srst && !stop_ev && (hs_reg || (ack_slot && is_mcode));
  end

  // =====================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_mcode_nack;
    ack_slot && is_mcode |-> sda && !sda_s_oe;
  endproperty
  a_mcode_nack: assert property (p_mcode_nack)
    else $error("master code acknowledged");

  property p_addr_ack;
    ack_slot && is_addr |-> !sda && sda_s_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_other_nack;
    ack_slot && first_reg && !is_addr |-> !sda_s_oe;
  endproperty
  a_other_nack: assert property (p_other_nack)
    else $error("foreign first byte acknowledged");

  property p_mcode_own;
    ack_slot && is_mcode |-> sh_reg[2:0] != 3'h0;
  endproperty
  a_mcode_own: assert property (p_mcode_own)
    else $error("reserved test master code used");

  property p_stop_release;
    stop_ev |=> (!sda_s_oe && !scl_s_oe) [*8];
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("lines held after stop");

  property p_pullup_in_hs;
    hs_pullup_en |-> hs_reg || $past(hs_reg, 8);
  endproperty
  a_pullup_in_hs: assert property (p_pullup_in_hs)
    else $error("pull-up on outside high speed");

  property p_pullup_wait;
    $rose(hs_pullup_en) |-> $past(scl);
  endproperty
  a_pullup_wait: assert property (p_pullup_wait)
    else $error("pull-up on before clock high");

  property p_pullup_off;
    scl_m_oe |=> !hs_pullup_en;
  endproperty
  a_pullup_off: assert property (p_pullup_off)
    else $error("pull-up on while clock pulled low");

  property p_stretch_low;
    $rose(scl_s_oe) |-> !$past(scl);
  endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("stretch began on a high clock");

  property p_stretch_hs;
    scl_s_oe |-> hs_reg;
  endproperty
  a_stretch_hs: assert property (p_stretch_hs)
    else $error("clock stretched outside high speed");

  c_hs_entry: cover property (ack_slot && is_mcode);
  c_chain_sr: cover property (start_ev && hs_reg);
  c_stretch:  cover property ($rose(scl_s_oe));
endmodule

// >>> testbench/pmic_i2c_hs_slave_tb.sv
`timescale 1ns/1ps
module pmic_i2c_hs_slave_tb;
  import pmic_i2c_pkg::*;

  // =====================================================
  // Signals
  logic       clk_sys;
  logic       srst;
  logic       cmd_valid;
  logic       cmd_ready;
  logic       cmd_read;
  logic       cmd_hs;
  logic       cmd_chain;
  byte_t      cmd_index;
  byte_t      cmd_wdata;
  logic       rsp_valid;
  byte_t      rsp_rdata;
  logic       rsp_nack;
  logic       rsp_lost;
  logic       hs_host;
  logic       hs_dev;
  logic       hold_req;
  logic       hold_en;
  logic [5:0] hold_cnt;
  byte_t      vcore_code;
  byte_t      rail_en;
  byte_t      pwm_sel;
  byte_t      sleep_ctrl;
  byte_t      wake_seq;
  int         errors      = 0;
  int         checks_done = 0;
  int         cycles      = 0;

  i2c_link_if link ();

  pmic_i2c_host u_pmic_i2c_host (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .link      (link),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_read  (cmd_read),
    .cmd_hs    (cmd_hs),
    .cmd_chain (cmd_chain),
    .cmd_index (cmd_index),
    .cmd_wdata (cmd_wdata),
    .rsp_valid (rsp_valid),
    .rsp_rdata (rsp_rdata),
    .rsp_nack  (rsp_nack),
    .rsp_lost  (rsp_lost),
    .hs_active (hs_host)
  );

  pmic_i2c_dev u_pmic_i2c_dev (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .link       (link),
    .hold_req   (hold_req),
    .vcore_code (vcore_code),
    .rail_en    (rail_en),
    .pwm_sel    (pwm_sel),
    .sleep_ctrl (sleep_ctrl),
    .wake_seq   (wake_seq),
    .hs_active  (hs_dev)
  );

  pmic_i2c_hs_slave_props u_pmic_i2c_hs_slave_props (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .scl_m_oe     (link.scl_m_oe),
    .scl_s_oe     (link.scl_s_oe),
    .sda_s_oe     (link.sda_s_oe),
    .hs_pullup_en (link.hs_pullup_en),
    .scl          (link.scl),
    .sda          (link.sda)
  );

  // =====================================================
  // Clock, stretch pattern and hang guard
  always #2.5 clk_sys = ~clk_sys;

  // Stretch requests come in bursts so every hold is released again
  always @(posedge clk_sys) begin
    #1;
    hold_cnt = hold_cnt + 6'h1;
    hold_req = hold_en && (hold_cnt < 6'h18);
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      complete_run();
    end
  end

  // =====================================================
  // Shared tasks
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input byte_t seen, input byte_t exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic run_cmd(input logic rd, input logic hs, input logic ch, input byte_t idx,
                         input byte_t wd);
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd_read  = rd;
    cmd_hs    = hs;
    cmd_chain = ch;
    cmd_index = idx;
    cmd_wdata = wd;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    #1;
    cmd_valid = 1'b0;
    do @(posedge clk_sys); while (rsp_valid !== 1'b1);
    #1;
  endtask

  // =====================================================
  // Scenarios
  task automatic t_reset_values;
    check(vcore_code, 8'h1e, "vcore reset");
    check(rail_en, 8'h0f, "rail reset");
    check(pwm_sel, 8'h00, "pwm reset");
    check(sleep_ctrl, 8'h03, "sleep reset");
    check(wake_seq, 8'h00, "wake reset");
    check(byte_t'(hs_dev), 8'h00, "hs after reset");
  endtask

  task automatic t_fs_write_read;
    run_cmd(1'b0, 1'b0, 1'b0, REG_VCORE, 8'h2a);
    check(byte_t'(rsp_nack), 8'h00, "fs write nack");
    check(vcore_code, 8'h2a, "fs write vcore");
    run_cmd(1'b1, 1'b0, 1'b0, REG_VCORE, 8'h00);
    check(rsp_rdata, 8'h2a, "fs read vcore");
    check(byte_t'(rsp_nack), 8'h00, "fs read nack");
    check(byte_t'(hs_host), 8'h00, "fs stays fs");
  endtask

  task automatic t_hs_chain;
    hold_en = 1'b1;
    run_cmd(1'b0, 1'b1, 1'b1, REG_RAIL, 8'h05);
    check(byte_t'(rsp_nack), 8'h00, "hs address ack");
    check(byte_t'(rsp_lost), 8'h00, "hs arbitration");
    check(rail_en, 8'h05, "hs write rail");
    check(byte_t'(hs_dev), 8'h01, "hs held at sr");
    check(byte_t'(hs_host), 8'h01, "host hs held");
    run_cmd(1'b0, 1'b1, 1'b0, REG_SLEEP, 8'h01);
    check(sleep_ctrl, 8'h01, "chained write");
    // Edge detection lags the line by three cycles
    repeat (10) @(posedge clk_sys);
    check(byte_t'(hs_dev), 8'h00, "fs after stop");
    check(byte_t'(hs_host), 8'h00, "host fs after stop");
    check(byte_t'({link.scl, link.sda}), 8'h03, "bus idle");
  endtask

  task automatic t_hs_limits;
    run_cmd(1'b0, 1'b1, 1'b0, REG_VCORE, 8'h50);
    check(vcore_code, VCORE_MAX_CODE, "vcore clamp");
    run_cmd(1'b1, 1'b1, 1'b0, REG_LIMIT, 8'h00);
    check(rsp_rdata, 8'h00, "unmapped read");
    hold_en = 1'b0;
    run_cmd(1'b0, 1'b1, 1'b0, REG_WAKE, 8'h07);
    check(wake_seq, 8'h07, "wake write");
    check(pwm_sel, 8'h00, "pwm untouched");
  endtask

  // =====================================================
  // Main sequence
  initial begin
    clk_sys   = 1'b0;
    srst      = 1'b1;
    cmd_valid = 1'b0;
    cmd_read  = 1'b0;
    cmd_hs    = 1'b0;
    cmd_chain = 1'b0;
    cmd_index = 8'h00;
    cmd_wdata = 8'h00;
    hold_en   = 1'b0;
    hold_req  = 1'b0;
    hold_cnt  = 6'h00;
    repeat (2) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    t_reset_values();
    t_fs_write_read();
    t_hs_chain();
    t_hs_limits();
    complete_run();
  end
endmodule
